// file: inc/fnfd_pkg.sv
// Package for the fractional-N feedback divider: register map, field layout,
// configuration carrier, calibration states and timing constants.
// Assumes a 250 MHz core clock and 32-bit software data.
package fnfd_pkg;

    localparam int unsigned CLK_MHZ = 250;

    // Register byte addresses.
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_PATH   = 8'h04;
    localparam logic [7:0] ADDR_NINT   = 8'h08;
    localparam logic [7:0] ADDR_NUM    = 8'h0C;
    localparam logic [7:0] ADDR_DEN    = 8'h10;
    localparam logic [7:0] ADDR_RATIO  = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    localparam int unsigned CTRL_CAL_BIT = 3;

    localparam int unsigned NINT_W  = 12;
    localparam int unsigned FRAC_W  = 32;
    localparam int unsigned RDIV_W  = 8;
    localparam int unsigned MULT_W  = 5;
    localparam int unsigned ORDER_W = 3;
    localparam int unsigned SIG_W   = 5;

    localparam logic [ORDER_W-1:0] ORDER_MAX    = 3'h4;
    localparam logic [1:0]         LOOP_SINGLE  = 2'h3;
    localparam logic [2:0]         PRESCALE_LO  = 3'h2;
    localparam logic [2:0]         PRESCALE_HI  = 3'h4;

    // Reset values.
    localparam logic [NINT_W-1:0] NINT_RST = 12'h0064;
    localparam logic [FRAC_W-1:0] DEN_RST  = 32'h0000_0001;
    localparam logic [31:0]       PATH_RST = 32'h0004_4000;
    localparam logic [31:0]       RATIO_RST = 32'h0001_0101;

    // Time the tuning voltage is held at mid-scale before the oscillator trim.
    localparam int unsigned CAL_MID_NS   = 1000;
    localparam int unsigned CAL_MID_CYC  = (CAL_MID_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CAL_REF_EDGES = 16;

    // Reference path and loop setup, laid out as the path register.
    typedef struct packed {
        logic [9:0]         spare;
        logic [3:0]         delaySel;
        logic [3:0]         cpGain;
        logic [1:0]         highCalAdj;
        logic [1:0]         lowCalAdj;
        logic [1:0]         loopCtl;
        logic [ORDER_W-1:0] mashOrder;
        logic               prescale4;
        logic               postDivEn;
        logic               multEn;
        logic               preDivEn;
        logic               doublerEn;
    } fnfd_cfg_t;

    typedef struct packed {
        logic [RDIV_W-1:0] postDiv;
        logic [RDIV_W-1:0] preDiv;
        logic [RDIV_W-1:0] mult;
    } fnfd_ratio_t;

    typedef enum logic [1:0] {
        CAL_IDLE  = 2'b00,
        CAL_FORCE = 2'b01,
        CAL_TRIM  = 2'b11,
        CAL_DONE  = 2'b10
    } fnfd_cal_t;

endpackage

// file: logic/fnfd_pulse_div.sv
// Pulse-rate divider: one output pulse per ratio input pulses.
// Assumes single-cycle input pulses on clk; a ratio of zero acts as one.
`timescale 1ns/1ps
module fnfd_pulse_div #(
    parameter int unsigned W = 8
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         inPulse,
    input  wire logic         bypass,
    input  wire logic [W-1:0] ratio,
    output logic              outPulse
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic         out_ff;
    logic         nxt_out;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_out = 1'b0;
        if (bypass) begin
            nxt_cnt = '0;
            nxt_out = inPulse;
        end else if (inPulse) begin
            if ((cnt_ff + W'(1)) >= ratio) begin
                nxt_cnt = '0;
                nxt_out = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= '0;
            out_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            out_ff <= nxt_out;
        end
    end

    assign outPulse = out_ff;
endmodule

// file: logic/fnfd_mash_stage.sv
// One first-order accumulator stage of the noise-shaping modulator.
// Assumes the denominator is nonzero and the increment below it.
`timescale 1ns/1ps
module fnfd_mash_stage #(
    parameter int unsigned W = 32
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         clr,
    input  wire logic         adv,
    input  wire logic         en,
    input  wire logic [W-1:0] inc,
    input  wire logic [W-1:0] den,
    output logic [W-1:0]      acc,
    output logic              carry
);
    logic [W-1:0] acc_ff;
    logic [W-1:0] nxt_acc;
    logic         carry_ff;
    logic         nxt_carry;
    logic [W:0]   sum;

    always_comb begin
        sum       = {1'b0, acc_ff} + {1'b0, inc};
        nxt_acc   = acc_ff;
        nxt_carry = carry_ff;
        if (clr || !en) begin
            nxt_acc   = '0;
            nxt_carry = 1'b0;
        end else if (adv) begin
            // Wraps modulo the denominator, not a power of two.
            if (sum >= {1'b0, den}) begin
                nxt_acc   = W'(sum - {1'b0, den});
                nxt_carry = 1'b1;
            end else begin
                nxt_acc   = sum[W-1:0];
                nxt_carry = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_ff   <= '0;
            carry_ff <= 1'b0;
        end else begin
            acc_ff   <= nxt_acc;
            carry_ff <= nxt_carry;
        end
    end

    assign acc   = acc_ff;
    assign carry = carry_ff;
endmodule

// file: logic/fnfd_top.sv
// Digital core of the synthesizer loop: reference path, phase detector,
// prescaler, fractional feedback divider and oscillator calibration control.
// Assumes reference and oscillator arrive as asynchronous logic levels slower
// than half the core clock, and software uses the single-cycle register port.
`timescale 1ns/1ps
// Operation
// - Integer feedback divide is twelve programmable bits.
// - Modulator order one to four, or integer.
// - Denominator is thirty-two bits, one upward.
// - Average divide equals integer plus numerator/denominator.
// - Prescaler divides oscillator by two or four.
// - Oscillator equals detector times prescale times ratio.
// - Step is detector times prescale over denominator.
// - Dual-loop detector is the default mode.
// - Detector compares reference and feedback; gain programmable.
// - Each reference stage can be bypassed.
// - Doubler pulses on both reference edges.
// - Each calibration forces tuning mid-scale first.
// - Writing control with trigger bit starts calibration.
module fnfd_top
#(
    parameter int unsigned MID_CYC   = fnfd_pkg::CAL_MID_CYC,
    parameter int unsigned REF_EDGES = fnfd_pkg::CAL_REF_EDGES
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 referenceInput,
    input  wire logic                 oscillatorInput,
    input  wire logic [7:0]           regAddr,
    input  wire logic [31:0]          regWrData,
    input  wire logic                 regWr,
    input  wire logic                 regRd,
    output logic [31:0]               regRdData,
    output logic                      chargeUp,
    output logic                      chargeDn,
    output logic [3:0]                cpGain,
    output logic                      singleLoop,
    output logic                      vtuneMid,
    output logic                      calBusy,
    output logic                      detRefPulse,
    output logic                      detFbPulse
);
    import fnfd_pkg::*;
    // Input synchronisers; only the second stage is looked at.
    logic [1:0] refSync_ff;
    logic [1:0] oscSync_ff;
    logic       refLast_ff;
    logic       oscLast_ff;

    // Software state.
    fnfd_cfg_t         cfg_ff,   nxt_cfg;
    fnfd_ratio_t       ratio_ff, nxt_ratio;
    logic [NINT_W-1:0] nInt_ff,  nxt_nInt;
    logic [FRAC_W-1:0] num_ff,   nxt_num;
    logic [FRAC_W-1:0] den_ff,   nxt_den;
    logic [31:0]       rd_ff,    nxt_rd;
    logic              calStart;
    // Calibration.
    fnfd_cal_t cal_ff, nxt_cal;
    logic [15:0] calCnt_ff, nxt_calCnt;
    // Multiplier burst, detector and modulator state.
    logic [RDIV_W-1:0] burst_ff, nxt_burst;
    logic              burstGap_ff, nxt_burstGap;
    logic              up_ff, nxt_up;
    logic              dn_ff, nxt_dn;
    logic [3:0]        dly_ff, nxt_dly;
    logic signed [SIG_W-1:0] sigD_ff [2:4];
    logic signed [SIG_W-1:0] nxt_sigD [2:4];
    logic              refP_ff, fbP_ff, mid_ff, busy_ff, loop_ff;

    logic refRise, refFall, oscRise, dblPulse, preOut, multPulse, postOut;
    logic psOut, fbWrap;
    logic [2:0] psRatio;
    logic [NINT_W:0] fbRatio;
    logic signed [SIG_W-1:0] sig [1:4];
    logic signed [NINT_W+1:0] nSum;
    logic [FRAC_W-1:0] acc [0:4];
    logic [4:1] carry;
    logic fracEn;

    assign refRise = refSync_ff[1] & ~refLast_ff;
    assign refFall = ~refSync_ff[1] & refLast_ff;
    assign oscRise = oscSync_ff[1] & ~oscLast_ff;

    // Register port.
    always_comb begin
        nxt_cfg   = cfg_ff;
        nxt_ratio = ratio_ff;
        nxt_nInt  = nInt_ff;
        nxt_num   = num_ff;
        nxt_den   = den_ff;
        nxt_rd    = '0;
        calStart  = 1'b0;
        if (regWr) begin
            case (regAddr)
                ADDR_CTRL:  calStart = regWrData[CTRL_CAL_BIT];
                ADDR_PATH:  nxt_cfg   = fnfd_cfg_t'(regWrData);
                ADDR_NINT:  nxt_nInt  = regWrData[NINT_W-1:0];
                ADDR_NUM:   nxt_num   = regWrData;
                ADDR_DEN:   nxt_den   = regWrData;
                ADDR_RATIO: nxt_ratio = fnfd_ratio_t'(regWrData[3*RDIV_W-1:0]);
                default: ;
            endcase
        end
        if (regRd) begin
            case (regAddr)
                ADDR_PATH:   nxt_rd = 32'(cfg_ff);
                ADDR_NINT:   nxt_rd = 32'(nInt_ff);
                ADDR_NUM:    nxt_rd = num_ff;
                ADDR_DEN:    nxt_rd = den_ff;
                ADDR_RATIO:  nxt_rd = 32'(ratio_ff);
                ADDR_STATUS: nxt_rd = {17'h0_0000, 2'(cal_ff), fbRatio};
                default:     nxt_rd = '0;
            endcase
        end
    end

    // Reference path: doubler, pre-divider, multiplier, post-divider.
    assign dblPulse = refRise | (cfg_ff.doublerEn & refFall);

    fnfd_pulse_div #(.W(RDIV_W)) u_preDiv (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inPulse  (dblPulse),
        .bypass   (~cfg_ff.preDivEn),
        .ratio    (ratio_ff.preDiv),
        .outPulse (preOut)
    );

    // The multiplier replays each input pulse as a burst spaced two cycles
    // apart, so it only holds its ratio while the input is slow enough.
    always_comb begin
        nxt_burst    = burst_ff;
        nxt_burstGap = 1'b0;
        multPulse    = 1'b0;
        if (!cfg_ff.multEn) begin
            multPulse = preOut;
            nxt_burst = '0;
        end else if (preOut) begin
            nxt_burst = ratio_ff.mult;
        end else if (burst_ff != '0 && !burstGap_ff) begin
            multPulse    = 1'b1;
            nxt_burstGap = 1'b1;
            nxt_burst    = burst_ff - RDIV_W'(1);
        end
    end

    fnfd_pulse_div #(.W(RDIV_W)) u_postDiv (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inPulse  (multPulse),
        .bypass   (~cfg_ff.postDivEn),
        .ratio    (ratio_ff.postDiv),
        .outPulse (postOut)
    );
    // Prescaler then feedback divider.
    assign psRatio = cfg_ff.prescale4 ? PRESCALE_HI : PRESCALE_LO;
    fnfd_pulse_div #(.W(3)) u_prescale (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inPulse  (oscRise),
        .bypass   (1'b0),
        .ratio    (psRatio),
        .outPulse (psOut)
    );

    fnfd_pulse_div #(.W(NINT_W+1)) u_fbDiv (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inPulse  (psOut),
        .bypass   (1'b0),
        .ratio    (fbRatio),
        .outPulse (fbWrap)
    );

    // Modulator stages advance once per feedback cycle.
    assign acc[0] = num_ff;
    assign fracEn = (den_ff != '0) && (cal_ff == CAL_IDLE);

    genvar k;
    generate
        for (k = 1; k <= 4; k++) begin : g_stage
            fnfd_mash_stage #(.W(FRAC_W)) u_stage (
                .clk     (clk),
                .sys_rst (sys_rst),
                .clr     (calStart),
                .adv     (fbWrap),
                .en      (fracEn && (cfg_ff.mashOrder >= ORDER_W'(k))
                          && (cfg_ff.mashOrder <= ORDER_MAX)),
                .inc     (acc[k-1]),
                .den     (den_ff),
                .acc     (acc[k]),
                .carry   (carry[k])
            );
        end
    endgenerate

    // Cascade recombination: each lower stage adds the difference of the next.
    always_comb begin
        sig[4] = $signed({4'h0, carry[4]});
        for (int i = 3; i >= 1; i--) begin
            sig[i] = $signed({4'h0, carry[i]}) + sig[i+1] - sigD_ff[i+1];
        end
        for (int i = 2; i <= 4; i++) begin
            nxt_sigD[i] = fbWrap ? sig[i] : sigD_ff[i];
        end
        nSum = $signed({2'b00, nInt_ff}) + (NINT_W+2)'(sig[1]);
        if (nSum < 1) begin
            fbRatio = (NINT_W+1)'(1);
        end else begin
            fbRatio = nSum[NINT_W:0];
        end
    end

    // Phase detector with a programmable reset delay.
    always_comb begin
        nxt_up  = up_ff | postOut;
        nxt_dn  = dn_ff | fbWrap;
        nxt_dly = '0;
        if (cal_ff != CAL_IDLE) begin
            nxt_up = 1'b0;
            nxt_dn = 1'b0;
        end else if (up_ff && dn_ff) begin
            // Both sides stay on for the delay to avoid a dead zone.
            nxt_dly = dly_ff + 4'h1;
            if (dly_ff >= cfg_ff.delaySel) begin
                nxt_up  = postOut;
                nxt_dn  = fbWrap;
                nxt_dly = '0;
            end
        end
    end

    // Calibration: hold tuning at mid-scale, then trim against the reference.
    always_comb begin
        nxt_cal    = cal_ff;
        nxt_calCnt = calCnt_ff;
        case (cal_ff)
            CAL_IDLE: nxt_calCnt = '0;
            CAL_FORCE: begin
                nxt_calCnt = calCnt_ff + 16'h0001;
                if (calCnt_ff >= 16'(MID_CYC - 1)) begin
                    nxt_cal    = CAL_TRIM;
                    nxt_calCnt = '0;
                end
            end
            CAL_TRIM: begin
                // Reference edges pace the trim, so a dead reference stalls it.
                if (refRise) begin
                    nxt_calCnt = calCnt_ff + 16'h0001;
                end
                if (calCnt_ff >= 16'(REF_EDGES)) begin
                    nxt_cal = CAL_DONE;
                end
            end
            CAL_DONE: nxt_cal = CAL_IDLE;
            default:  nxt_cal = CAL_IDLE;
        endcase
        if (calStart) begin
            nxt_cal    = CAL_FORCE;
            nxt_calCnt = '0;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            refSync_ff  <= 2'h0;
            oscSync_ff  <= 2'h0;
            refLast_ff  <= 1'b0;
            oscLast_ff  <= 1'b0;
            cfg_ff      <= fnfd_cfg_t'(PATH_RST);
            ratio_ff    <= fnfd_ratio_t'(RATIO_RST[3*RDIV_W-1:0]);
            nInt_ff     <= NINT_RST;
            num_ff      <= '0;
            den_ff      <= DEN_RST;
            rd_ff       <= '0;
            cal_ff      <= CAL_IDLE;
            calCnt_ff   <= '0;
            burst_ff    <= '0;
            burstGap_ff <= 1'b0;
            up_ff       <= 1'b0;
            dn_ff       <= 1'b0;
            dly_ff      <= '0;
            refP_ff     <= 1'b0;
            fbP_ff      <= 1'b0;
            mid_ff      <= 1'b0;
            busy_ff     <= 1'b0;
            loop_ff     <= 1'b0;
            sigD_ff     <= '{default: '0};
        end else begin
            refSync_ff  <= {refSync_ff[0], referenceInput};
            oscSync_ff  <= {oscSync_ff[0], oscillatorInput};
            refLast_ff  <= refSync_ff[1];
            oscLast_ff  <= oscSync_ff[1];
            cfg_ff      <= nxt_cfg;
            ratio_ff    <= nxt_ratio;
            nInt_ff     <= nxt_nInt;
            num_ff      <= nxt_num;
            den_ff      <= nxt_den;
            rd_ff       <= nxt_rd;
            cal_ff      <= nxt_cal;
            calCnt_ff   <= nxt_calCnt;
            burst_ff    <= nxt_burst;
            burstGap_ff <= nxt_burstGap;
            up_ff       <= nxt_up;
            dn_ff       <= nxt_dn;
            dly_ff      <= nxt_dly;
            refP_ff     <= postOut;
            fbP_ff      <= fbWrap;
            mid_ff      <= nxt_cal == CAL_FORCE;
            busy_ff     <= nxt_cal != CAL_IDLE;
            loop_ff     <= nxt_cfg.loopCtl == LOOP_SINGLE;
            sigD_ff     <= nxt_sigD;
        end
    end

    assign regRdData   = rd_ff;
    assign chargeUp    = up_ff;
    assign chargeDn    = dn_ff;
    assign cpGain      = cfg_ff.cpGain;
    assign singleLoop  = loop_ff;
    assign vtuneMid    = mid_ff;
    assign calBusy     = busy_ff;
    assign detRefPulse = refP_ff;
    assign detFbPulse  = fbP_ff;
endmodule

// file: testbench/fnfd_source_model.sv
// Reference and oscillator source model for the divider core bench.
// Assumes a free-running core clock; both sources change on its edges.
`timescale 1ns/1ps
module fnfd_source_model #(
    parameter int REF_HALF = 6,
    parameter int OSC_HALF = 2
) (
    input  wire logic clk,
    input  wire logic refOn,
    output logic      referenceInput,
    output logic      oscillatorInput
);
    int refDiv = 0;
    int oscDiv = 0;
    initial referenceInput = 1'b0;
    initial oscillatorInput = 1'b0;
    // Equal high and low times keep both reference edges usable.
    // A missing source is held low so calibration sees no edges.
    always @(posedge clk) begin
        refDiv <= (refDiv == REF_HALF - 1) ? 0 : refDiv + 1;
        oscDiv <= (oscDiv == OSC_HALF - 1) ? 0 : oscDiv + 1;
        if (!refOn) begin
            referenceInput <= 1'b0;
        end else if (refDiv == REF_HALF - 1) begin
            referenceInput <= ~referenceInput;
        end
        if (oscDiv == OSC_HALF - 1) begin
            oscillatorInput <= ~oscillatorInput;
        end
    end
endmodule

// file: testbench/fnfd_top_monitor.sv
// Checker for the divider core: calibration, register port and detector.
// Assumes one clock domain and sees only the top module's ports.
`timescale 1ns/1ps
module fnfd_top_monitor
    import fnfd_pkg::*;
#(
    parameter int unsigned MID_CYC   = CAL_MID_CYC,
    parameter int unsigned REF_EDGES = CAL_REF_EDGES
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdData,
    input wire logic        chargeUp,
    input wire logic        chargeDn,
    input wire logic [3:0]  cpGain,
    input wire logic        singleLoop,
    input wire logic        vtuneMid,
    input wire logic        calBusy,
    input wire logic        detFbPulse
);
    logic [15:0] midCnt_ff;
    logic [15:0] nxt_midCnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    always_comb nxt_midCnt = vtuneMid ? midCnt_ff + 16'h0001 : 16'h0000;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            midCnt_ff <= 16'h0000;
        end else begin
            midCnt_ff <= nxt_midCnt;
        end
    end
    sequence sCalReq;
        regWr && regAddr == ADDR_CTRL && regWrData[CTRL_CAL_BIT];
    endsequence
    sequence sPathWr;
        regWr && regAddr == ADDR_PATH;
    endsequence
    a_cal_start: assert property (sCalReq |=> calBusy && vtuneMid)
        else $error("calibration did not start");
    a_mid_length: assert property ($fell(vtuneMid) |-> midCnt_ff == MID_CYC)
        else $error("mid-scale hold has the wrong length");
    a_mid_in_cal: assert property (vtuneMid |-> calBusy)
        else $error("mid-scale forced outside calibration");
    a_trim_follows: assert property ($fell(vtuneMid) |-> calBusy)
        else $error("calibration ended without trim");
    a_pump_quiet: assert property (calBusy && $past(calBusy) |-> !chargeUp && !chargeDn)
        else $error("charge pump active during calibration");
    a_pump_release: assert property (chargeUp && chargeDn |-> ##[1:17] !(chargeUp && chargeDn))
        else $error("detector outputs not cleared");
    a_gain_write: assert property (sPathWr |=> cpGain == $past(regWrData[17:14]))
        else $error("pump gain does not follow path register");
    a_loop_mode: assert property (sPathWr |=> singleLoop == ($past(regWrData[9:8]) == LOOP_SINGLE))
        else $error("loop mode does not follow path register");
    a_ctrl_reads: assert property (regRd && regAddr == ADDR_CTRL |=> regRdData == 32'h0000_0000)
        else $error("control register does not read zero");
    a_fb_pulse: assert property (detFbPulse |=> !detFbPulse)
        else $error("feedback pulse longer than one cycle");
endmodule
bind fnfd_top fnfd_top_monitor #(.MID_CYC(MID_CYC), .REF_EDGES(REF_EDGES)) uMon (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .chargeUp(chargeUp),
    .chargeDn(chargeDn), .cpGain(cpGain), .singleLoop(singleLoop),
    .vtuneMid(vtuneMid), .calBusy(calBusy), .detFbPulse(detFbPulse));

// file: testbench/fnfd_top_tb.sv
// Bench for the divider core: registers, reference path, feedback averages
// and calibration. Assumes the source model drives reference and oscillator.
`timescale 1ns/1ps
module fnfd_top_tb;
    import fnfd_pkg::*;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        refOn = 1'b1;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [31:0] regRdData;
    logic [3:0]  cpGain;
    logic        chargeUp, chargeDn, singleLoop, vtuneMid, calBusy;
    logic        detRefPulse, detFbPulse, refIn, reference_input, oscPrev;
    int          errorCnt = 0, nChecks = 0, cyc = 0;
    int          oscCnt = 0, fbCnt = 0, refCnt = 0, pumpCnt = 0;
    fnfd_cfg_t   cfg;
    logic [31:0] rdv;

    always #2 clk = ~clk;

    fnfd_source_model src (.clk(clk), .refOn(refOn), .referenceInput(refIn),
        .oscillatorInput(reference_input));
    fnfd_top #(.MID_CYC(8), .REF_EDGES(2)) uut (
        .clk(clk), .sys_rst(sys_rst), .referenceInput(refIn), .oscillatorInput(reference_input),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .chargeUp(chargeUp), .chargeDn(chargeDn),
        .cpGain(cpGain), .singleLoop(singleLoop), .vtuneMid(vtuneMid),
        .calBusy(calBusy), .detRefPulse(detRefPulse), .detFbPulse(detFbPulse));

    // Event counters let the tests measure average rates without racing the edge.
    always @(posedge clk) begin
        oscPrev <= reference_input;
        if (reference_input && !oscPrev) oscCnt <= oscCnt + 1;
        if (detFbPulse === 1'b1) fbCnt <= fbCnt + 1;
        if (detRefPulse === 1'b1) refCnt <= refCnt + 1;
        if (chargeUp === 1'b1 || chargeDn === 1'b1) pumpCnt <= pumpCnt + 1;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errorCnt++;
            summarize();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic near(input string name, input int exp, input int tol, input int got);
        nChecks++;
        if (got < exp - tol || got > exp + tol) begin
            errorCnt++;
            $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic waitFb(input int n);
        int t;
        t = 0;
        n = fbCnt + n;
        while (fbCnt < n && t < 9000) begin
            @(posedge clk);
            #1 t++;
        end
    endtask
    task automatic waitIdle();
        int t;
        t = 0;
        while (calBusy !== 1'b0 && t < 500) begin
            @(posedge clk);
            #1 t++;
        end
        check("calBusy", 32'h0000_0000, {31'h0, calBusy});
    endtask
    // Integer value 30 and the delay choice keep the per-order limits.
    task automatic fbTest(input int ord);
        int p, o0;
        p = (ord % 2) ? 4 : 2;
        cfg = PATH_RST;
        cfg.mashOrder = ord[2:0];
        cfg.prescale4 = (p == 4);
        cfg.delaySel = (ord > 3) ? 4'h8 : (ord > 1) ? 4'h2 : 4'h1;
        wr(ADDR_PATH, cfg);
        waitFb(3);
        o0 = oscCnt;
        waitFb(16);
        near("oscillator edges", p * (480 + (ord > 0 ? 4 : 0)),
            (ord > 1) ? 8 * p : p + 1, oscCnt - o0);
    endtask
    task automatic refTest(input logic [3:0] stages, input int exp);
        int r0;
        cfg = PATH_RST;
        cfg[3:0] = stages;
        wr(ADDR_PATH, cfg);
        repeat (48) @(posedge clk);
        r0 = refCnt;
        repeat (480) @(posedge clk);
        near("reference pulses", exp, 1, refCnt - r0);
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        logic [7:0]  ra [8];
        logic [31:0] re [8];
        logic [3:0]  stg [5];
        int          ex [5];
        ra = '{ADDR_PATH, ADDR_NINT, ADDR_NUM, ADDR_DEN, ADDR_RATIO, ADDR_CTRL,
               ADDR_STATUS, 8'h1C};
        re = '{PATH_RST, 32'(NINT_RST), 32'h0, DEN_RST, RATIO_RST, 32'h0, 32'h64, 32'h0};
        stg = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
        ex = '{40, 80, 10, 80, 8};
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (ra[i]) begin
            rd(ra[i], rdv);
            check("reset value", re[i], rdv);
        end
        check("singleLoop", 32'h0, {31'h0, singleLoop});
        $display("test reset values done");
        wr(ADDR_NINT, 32'hFFFF_FFFF);
        wr(ADDR_DEN, 32'hFFFF_FFFF);
        rd(ADDR_NINT, rdv);
        check("integer value", 32'h0000_0FFF, rdv);
        rd(ADDR_DEN, rdv);
        check("denominator", 32'hFFFF_FFFF, rdv);
        rd(ADDR_STATUS, rdv);
        check("feedback ratio", 32'h0000_0FFF, {19'h0, rdv[12:0]});
        cfg = PATH_RST;
        cfg.loopCtl = LOOP_SINGLE;
        cfg.cpGain = 4'hA;
        wr(ADDR_PATH, cfg);
        check("singleLoop", 32'h1, {31'h0, singleLoop});
        check("cpGain", 32'hA, {28'h0, cpGain});
        $display("test register fields done");
        wr(ADDR_RATIO, 32'h0005_0402);
        foreach (stg[i]) refTest(stg[i], ex[i]);
        $display("test reference path done");
        wr(ADDR_NINT, 32'h0000_001E);
        wr(ADDR_NUM, 32'h0000_0001);
        wr(ADDR_DEN, 32'h0000_0004);
        for (int o = 0; o <= 4; o++) fbTest(o);
        near("pump activity", 1, 0, (pumpCnt > 0) ? 1 : 0);
        $display("test feedback divider done");
        wr(ADDR_CTRL, 32'h0000_0007);
        #1 check("calBusy", 32'h0, {31'h0, calBusy});
        wr(ADDR_CTRL, 32'h0000_0008);
        #1 check("vtuneMid", 32'h1, {31'h0, vtuneMid});
        rd(ADDR_STATUS, rdv);
        check("cal state", 32'h1, {30'h0, rdv[14:13]});
        waitIdle();
        @(posedge clk);
        refOn <= 1'b0;
        wr(ADDR_CTRL, 32'h0000_0008);
        repeat (200) @(posedge clk);
        rd(ADDR_STATUS, rdv);
        check("cal state", 32'h3, {30'h0, rdv[14:13]});
        refOn <= 1'b1;
        waitIdle();
        $display("test calibration done");
        summarize();
    end
endmodule
